/* File: verilog/rioc_regs.svh */
`ifndef RIOC_REGS_SVH
`define RIOC_REGS_SVH
// Overview of operation
// (R01) read ten switches for addresses, security, rate
// (R02) address is two-switch code plus one
// (R03) own transmit address received flags loopback
// (R04) loopback lights loop, darkens link-OK
// (R05) loopback forces all contact outputs off
// (R06) peer transmit address equals local receive address
// (R07) keep transmit and receive addresses different
// (R08) security off: output follows every valid frame
// (R09) security on: two matching frames change output
// (R10) switches 5..8 govern output pairs independently
// (R11) switches 10,9 pick rate; on/on reserved
// (R12) fiber fastest rate, multiplexed links slower
// (R13) peer uses eight-bit frame format
// (R14) peer runs the locally selected bit rate
// (R15) no link: relay off, alarm indicator lit
// (R16) link up: indicators lit, relay energized
// (R17) test button lights every indicator
// (R18) contact input lights indicator, sets sent bit
// (R19) receive error: link-OK off, relay off later
// (R20) faulty channel deasserts all contact outputs; the code holds them through the error delay and clears them at link down
// (R21) two successive errors start resynchronization
// (R22) eight contact inputs fill eight sent bits
// (R23) reserved rate treated as link down
// (R24) switches synchronized, filters cleared on change
`define RIOC_OFF_CTRL 8'h00
`define RIOC_OFF_STATUS 8'h04
`define RIOC_OFF_SWITCH 8'h08
`define RIOC_OFF_RXBITS 8'h0c
`define RIOC_OFF_OUTS 8'h10
`define RIOC_CTRL_RESET 32'h0000_0001
`define RIOC_CTRL_EN_BIT 0
`define RIOC_CTRL_RESYNC_BIT 1
`define RIOC_ST_LINKOK_BIT 0
`define RIOC_ST_LOOP_BIT 1
`define RIOC_ST_RELAY_BIT 2
`define RIOC_ST_RESV_BIT 3
`define RIOC_ST_ERR_BIT 4
`define RIOC_CLK_HZ 200000000
`define RIOC_ALARM_DELAY_MS 100
`define RIOC_ALARM_DELAY_CYC (`RIOC_ALARM_DELAY_MS * (`RIOC_CLK_HZ / 1000))
`define RIOC_RATE_HI 38400
`define RIOC_RATE_MID 19200
`define RIOC_RATE_LO 9600
`endif

/* File: verilog/rioc_pkg.sv */
package rioc_pkg;
  typedef enum logic [1:0] {
    RIOC_RATE_38400 = 2'b00,
    RIOC_RATE_19200 = 2'b01,
    RIOC_RATE_9600 = 2'b10,
    RIOC_RATE_RESV = 2'b11
  } rioc_rate_t;
  typedef enum logic [1:0] {
    RIOC_LINK_DOWN = 2'b00,
    RIOC_LINK_UP = 2'b01,
    RIOC_LINK_SUSPECT = 2'b10
  } rioc_link_t;
  // addresses held as code, i.e. address minus one
  typedef struct packed {
    logic [1:0] tx_addr;
    logic [1:0] rx_addr;
    logic [3:0] secure;
    rioc_rate_t rate;
  } rioc_cfg_t;
  typedef struct packed {
    logic valid;
    logic [1:0] addr;
    logic [7:0] bits;
  } rioc_frame_t;
endpackage

/* File: verilog/rioc_pair_filter.sv */
`timescale 1ns/100ps
`default_nettype none
module rioc_pair_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic frame_valid,
  input wire logic secure,
  input wire logic [1:0] bits,
  output logic [1:0] out_q
);
  logic [1:0] last_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 2'h0;
      last_q <= 2'h0;
    end else if (clear) begin
      out_q <= 2'h0;
      last_q <= 2'h0;
    end else if (frame_valid) begin
      last_q <= bits;
      if (!secure) begin
        out_q <= bits; // [R08]
      end else begin
        // bit changes only when two frames in a row agree
        out_q <= (bits & ~(bits ^ last_q)) | (out_q & (bits ^ last_q)); // [R09]
      end
    end
  end
endmodule // rioc_pair_filter
`default_nettype wire

/* File: verilog/rioc_delay_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module rioc_delay_timer #(
  parameter int unsigned CYCLES = 20000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic expired_q
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] count_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      expired_q <= 1'b0;
    end else if (!run) begin
      count_q <= '0;
      expired_q <= 1'b0;
    end else if (count_q == LAST) begin
      expired_q <= 1'b1;
    end else begin
      count_q <= count_q + W'(1);
    end
  end
endmodule // rioc_delay_timer
`default_nettype wire

/* File: verilog/rioc_top.sv */
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "rioc_regs.svh"
module rioc_top #(
  parameter int unsigned ALARM_DELAY_CYCLES = `RIOC_ALARM_DELAY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] config_switch,
  input wire logic [7:0] contact_input,
  input wire logic indicator_test_button,
  input wire logic rx_frame_valid,
  input wire logic [1:0] rx_frame_addr,
  input wire logic [7:0] rx_frame_bits,
  input wire logic rx_error,
  output logic [7:0] tx_frame_bits,
  output logic [1:0] tx_frame_addr,
  output logic [15:0] bit_period_cycles,
  output logic resync_request,
  output logic [7:0] contact_output,
  output logic [7:0] input_indicator,
  output logic [7:0] output_indicator,
  output logic link_ok_indicator,
  output logic loop_indicator,
  output logic alarm_indicator,
  output logic tx_activity_indicator,
  output logic rx_activity_indicator,
  output logic alarm_relay_energize
);
  // switch n sits at bit n-1, on reads as one
  function automatic rioc_pkg::rioc_cfg_t decode_switches(input logic [9:0] sw);
    rioc_pkg::rioc_cfg_t c;
    c.tx_addr = sw[1:0]; // [R02]
    c.rx_addr = sw[3:2]; // [R02]
    c.secure = sw[7:4]; // [R10]
    c.rate = rioc_pkg::rioc_rate_t'({sw[9], sw[8]}); // [R11]
    return c;
  endfunction

  function automatic logic [15:0] period_of(input rioc_pkg::rioc_rate_t r);
    logic [31:0] p;
    p = 32'h0;
    unique case (r)
      rioc_pkg::RIOC_RATE_38400: p = `RIOC_CLK_HZ / `RIOC_RATE_HI;
      rioc_pkg::RIOC_RATE_19200: p = `RIOC_CLK_HZ / `RIOC_RATE_MID;
      rioc_pkg::RIOC_RATE_9600: p = `RIOC_CLK_HZ / `RIOC_RATE_LO;
      rioc_pkg::RIOC_RATE_RESV: p = 32'h0;
    endcase
    return p[15:0];
  endfunction

  // switch synchroniser; the first stage feeds only the second
  logic [9:0] sw_meta_q;
  logic [9:0] sw_sync_q;
  rioc_pkg::rioc_cfg_t cfg_q;
  rioc_pkg::rioc_cfg_t cfg_new;
  logic cfg_change;
  logic cfg_valid_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_q <= 10'h000;
      sw_sync_q <= 10'h000;
    end else begin
      sw_meta_q <= config_switch; // [R24]
      sw_sync_q <= sw_meta_q; // [R24]
    end
  end

  assign cfg_new = decode_switches(sw_sync_q); // [R01]
  // the first compare after release always fires and loads the synchroniser's reset value;
  // a settled bank that differs from it is caught by a later compare
  assign cfg_change = (cfg_new != cfg_q) || !cfg_valid_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
      cfg_valid_q <= 1'b0;
    end else if (cfg_change) begin
      cfg_q <= cfg_new; // [R24]
      cfg_valid_q <= 1'b1;
    end
  end

  logic rate_resv;
  assign rate_resv = (cfg_q.rate == rioc_pkg::RIOC_RATE_RESV); // [R23]

  // register file
  logic [31:0] ctrl_q;
  logic link_en;
  logic apb_access;
  logic apb_commit;
  logic addr_hit;
  logic [31:0] rd_mux;
  logic sw_resync;

  assign link_en = ctrl_q[`RIOC_CTRL_EN_BIT];
  assign apb_access = psel && penable;
  assign apb_commit = apb_access && pready;
  assign sw_resync = apb_commit && pwrite && (paddr == `RIOC_OFF_CTRL) &&
                     pwdata[`RIOC_CTRL_RESYNC_BIT];

  // receive qualification
  rioc_pkg::rioc_frame_t frame;
  rioc_pkg::rioc_link_t link_q;
  logic loop_q;
  logic own_frame;
  logic good_frame;
  logic [1:0] err_run_q;
  logic err_pending_q;
  logic delay_done;
  logic [7:0] rx_bits_q;
  logic [7:0] filt_out;
  logic filt_clear;
  logic link_down_req;

  assign frame = '{valid: rx_frame_valid, addr: rx_frame_addr, bits: rx_frame_bits};
  // a frame bearing our own address wins over an address match
  assign own_frame = frame.valid && (frame.addr == cfg_q.tx_addr); // [R03] [R07]
  assign good_frame = frame.valid && !own_frame && (frame.addr == cfg_q.rx_addr) &&
                      !rate_resv && link_en && !cfg_change;
  assign link_down_req = cfg_change || rate_resv || !link_en;
  assign filt_clear = cfg_change; // [R24]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_q <= 1'b0;
    end else if (cfg_change) begin
      loop_q <= 1'b0;
    end else if (own_frame) begin
      loop_q <= 1'b1; // [R03]
    end else if (good_frame) begin
      loop_q <= 1'b0;
    end
  end

  // error seen and not yet cured by a good frame; a new error wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_pending_q <= 1'b0;
    end else if (link_down_req) begin
      err_pending_q <= 1'b0;
    end else if (rx_error) begin
      err_pending_q <= 1'b1; // [R19]
    end else if (good_frame) begin
      err_pending_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_run_q <= 2'h0;
      resync_request <= 1'b0;
    end else begin
      resync_request <= sw_resync;
      if (link_down_req) begin
        err_run_q <= 2'h0;
      end else if (rx_error) begin
        if (err_run_q == 2'h1) begin
          err_run_q <= 2'h0;
          resync_request <= 1'b1; // [R21]
        end else begin
          err_run_q <= 2'h1;
        end
      end else if (good_frame) begin
        err_run_q <= 2'h0;
      end
    end
  end

  rioc_delay_timer #(
    .CYCLES(ALARM_DELAY_CYCLES)
  ) u_alarm_delay (
    .clk(pclk),
    .rst_n(presetn),
    .run(err_pending_q && (link_q != rioc_pkg::RIOC_LINK_DOWN)),
    .expired_q(delay_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q <= rioc_pkg::RIOC_LINK_DOWN;
    end else if (link_down_req) begin
      link_q <= rioc_pkg::RIOC_LINK_DOWN; // [R23]
    end else begin
      unique case (link_q)
        rioc_pkg::RIOC_LINK_DOWN: begin
          if (good_frame && !rx_error) begin
            link_q <= rioc_pkg::RIOC_LINK_UP; // [R16]
          end
        end
        rioc_pkg::RIOC_LINK_UP: begin
          if (rx_error) begin
            link_q <= rioc_pkg::RIOC_LINK_SUSPECT; // [R19]
          end
        end
        rioc_pkg::RIOC_LINK_SUSPECT: begin
          if (delay_done) begin
            link_q <= rioc_pkg::RIOC_LINK_DOWN; // [R19]
          end else if (good_frame && !rx_error) begin
            link_q <= rioc_pkg::RIOC_LINK_UP;
          end
        end
        default: begin
          link_q <= rioc_pkg::RIOC_LINK_DOWN;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bits_q <= 8'h00;
    end else if (good_frame) begin
      rx_bits_q <= frame.bits;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pair
      rioc_pair_filter u_filter (
        .clk(pclk),
        .rst_n(presetn),
        .clear(filt_clear),
        .frame_valid(good_frame),
        .secure(cfg_q.secure[gi]), // [R10]
        .bits(frame.bits[2*gi+1:2*gi]),
        .out_q(filt_out[2*gi+1:2*gi])
      );
    end
  endgenerate

  // outputs act only on a live, non-looped link
  logic outputs_allowed;
  logic link_live;
  logic [7:0] out_next;
  logic lamp;

  assign link_live = (link_q != rioc_pkg::RIOC_LINK_DOWN);
  assign outputs_allowed = link_live && !loop_q && !link_down_req; // [R05] [R20]
  assign out_next = outputs_allowed ? filt_out : 8'h00; // [R05] [R20]
  assign lamp = indicator_test_button;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contact_output <= 8'h00;
      output_indicator <= 8'h00;
      input_indicator <= 8'h00;
    end else begin
      contact_output <= out_next;
      output_indicator <= lamp ? 8'hff : out_next; // [R17]
      input_indicator <= lamp ? 8'hff : contact_input; // [R18] [R17]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_frame_bits <= 8'h00;
      tx_frame_addr <= 2'h0;
      bit_period_cycles <= 16'h0000;
    end else begin
      tx_frame_bits <= contact_input; // [R22] [R18]
      tx_frame_addr <= cfg_q.tx_addr; // [R02]
      bit_period_cycles <= period_of(cfg_q.rate); // [R11]
    end
  end

  logic link_ok_d;
  logic relay_d;
  assign link_ok_d = (link_q == rioc_pkg::RIOC_LINK_UP) && !loop_q && !err_pending_q &&
                     !link_down_req; // [R04] [R19]
  // the relay holds through the error delay, dropping only at link down
  assign relay_d = link_live && !link_down_req; // [R15] [R16]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_ok_indicator <= 1'b0;
      loop_indicator <= 1'b0;
      alarm_indicator <= 1'b1;
      tx_activity_indicator <= 1'b0;
      rx_activity_indicator <= 1'b0;
      alarm_relay_energize <= 1'b0;
    end else begin
      link_ok_indicator <= lamp || link_ok_d; // [R04] [R16] [R17]
      loop_indicator <= lamp || loop_q; // [R04] [R17]
      alarm_indicator <= lamp || !relay_d; // [R15] [R17]
      tx_activity_indicator <= lamp || relay_d; // [R16] [R17]
      rx_activity_indicator <= lamp || relay_d; // [R16] [R17]
      alarm_relay_energize <= relay_d; // [R15] [R16]
    end
  end

  // apb slave: one wait state, answer on the second access cycle
  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `RIOC_OFF_CTRL: rd_mux = {31'h0, ctrl_q[`RIOC_CTRL_EN_BIT]};
      `RIOC_OFF_STATUS: rd_mux = {27'h0, err_pending_q, rate_resv, alarm_relay_energize,
                                  loop_q, link_ok_d};
      `RIOC_OFF_SWITCH: rd_mux = {22'h0, sw_sync_q};
      `RIOC_OFF_RXBITS: rd_mux = {24'h0, rx_bits_q};
      `RIOC_OFF_OUTS: rd_mux = {24'h0, contact_output};
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access && !pready;
      pslverr <= apb_access && !pready && !addr_hit;
      if (apb_access && !pready) begin
        prdata <= (pwrite || !addr_hit) ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // the resync bit is a strobe and never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `RIOC_CTRL_RESET;
    end else if (apb_commit && pwrite && (paddr == `RIOC_OFF_CTRL)) begin
      ctrl_q <= {31'h0, pwdata[`RIOC_CTRL_EN_BIT]};
    end
  end
endmodule // rioc_top
`default_nettype wire

/* File: testbench/rioc_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module rioc_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [9:0] config_switch,
  input wire logic [7:0] contact_input,
  input wire logic indicator_test_button,
  input wire logic rx_error,
  input wire logic [7:0] tx_frame_bits,
  input wire logic [15:0] bit_period_cycles,
  input wire logic resync_request,
  input wire logic [7:0] contact_output,
  input wire logic [7:0] input_indicator,
  input wire logic [7:0] output_indicator,
  input wire logic link_ok_indicator,
  input wire logic loop_indicator,
  input wire logic alarm_indicator,
  input wire logic tx_activity_indicator,
  input wire logic rx_activity_indicator,
  input wire logic alarm_relay_energize
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic lamp_q;
  logic calm;
  // indicators show the lamp override one edge late, so skip the edge after the button is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lamp_q <= 1'b0;
    else lamp_q <= indicator_test_button;
  end
  assign calm = !indicator_test_button && !lamp_q;
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  loop_gate_a: assert property (loop_indicator && calm |-> contact_output == 8'h00)
    else $error("outputs active in loopback");
  loop_ok_a: assert property (loop_indicator && calm |-> !link_ok_indicator)
    else $error("link ok lit in loopback");
  relay_alarm_a: assert property (!alarm_relay_energize && calm |-> alarm_indicator)
    else $error("alarm dark while relay off");
  lamp_all_a: assert property (indicator_test_button |=> &{link_ok_indicator, loop_indicator,
    alarm_indicator, tx_activity_indicator, rx_activity_indicator, input_indicator,
    output_indicator})
    else $error("indicator_test_button missed an indicator");
  tx_follow_a: assert property (tx_frame_bits == $past(contact_input))
    else $error("sent bits not from inputs");
  // software may also strobe a resync through a completed write
  resync_cause_a: assert property (resync_request |->
    ($past(rx_error) || $past(psel && penable && pready && pwrite)) ##1 !resync_request)
    else $error("resync without error");
  resv_down_a: assert property ((config_switch[9:8] == 2'b11) [*6] |->
    contact_output == 8'h00 && !alarm_relay_energize)
    else $error("reserved rate left link up");
  rate_fast_a: assert property ((config_switch[9:8] == 2'b00) [*6] |->
    bit_period_cycles == 16'h1458)
    else $error("fast rate period wrong");
  cover property (loop_indicator);
  cover property (resync_request);
  cover property (pslverr);
endmodule // rioc_top_asserts
bind rioc_top rioc_top_asserts rioc_top_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .pslverr, .config_switch, .contact_input, .indicator_test_button, .rx_error,
  .tx_frame_bits, .bit_period_cycles, .resync_request, .contact_output, .input_indicator,
  .output_indicator, .link_ok_indicator, .loop_indicator, .alarm_indicator,
  .tx_activity_indicator, .rx_activity_indicator, .alarm_relay_energize);
`default_nettype wire

/* File: testbench/rioc_peer_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rioc_peer_model (
  input wire logic pclk,
  input wire logic [15:0] bit_period_cycles,
  output logic rx_frame_valid,
  output logic [1:0] rx_frame_addr,
  output logic [7:0] rx_frame_bits,
  output logic rx_error
);
  logic [1:0] addr_q;
  logic [7:0] pay_q;
  logic [7:0] noise_q;
  initial begin
    rx_frame_valid = 1'b0;
    rx_error = 1'b0;
    addr_q = 2'b00;
    pay_q = 8'h00;
    noise_q = 8'h5a;
  end
  // outside a frame the lines toggle so a stale payload is never mistaken for data
  always @(posedge pclk) noise_q <= ~noise_q;
  assign rx_frame_bits = rx_frame_valid ? pay_q : noise_q;
  assign rx_frame_addr = rx_frame_valid ? addr_q : noise_q[1:0];
  // caller gives the peer's own transmit address, equal to the local receive address
  task automatic send(input logic [1:0] a, input logic [7:0] b);
    // the peer runs only at the locally selected rate; no link on the reserved code
    if (bit_period_cycles !== 16'h0000) begin
      @(posedge pclk);
      rx_frame_valid <= 1'b1;
      addr_q <= a;
      pay_q <= b;
      @(posedge pclk);
      rx_frame_valid <= 1'b0;
    end
  endtask
  task automatic fault();
    @(posedge pclk);
    rx_error <= 1'b1;
    @(posedge pclk);
    rx_error <= 1'b0;
  endtask
endmodule // rioc_peer_model
`default_nettype wire

/* File: testbench/rioc_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rioc_regs.svh"
module rioc_top_tb;
  localparam int unsigned DLY = 50;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, rx_frame_valid, rx_error, resync_request;
  logic [9:0] config_switch = 10'h004;
  logic [7:0] contact_input = 8'h00;
  logic indicator_test_button = 1'b0;
  logic [1:0] rx_frame_addr, tx_frame_addr;
  logic [7:0] rx_frame_bits, tx_frame_bits, contact_output, input_indicator, output_indicator;
  logic [15:0] bit_period_cycles;
  logic link_ok_indicator, loop_indicator, alarm_indicator;
  logic tx_activity_indicator, rx_activity_indicator, alarm_relay_energize;
  logic [15:0] period_tbl [4] = '{16'h1458, 16'h28b0, 16'h5161, 16'h0000};
  int fail_count = 0;
  int checks = 0;
  always #2.5 pclk = ~pclk;
  rioc_top #(.ALARM_DELAY_CYCLES(DLY)) rioc_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .config_switch, .contact_input,
    .indicator_test_button, .rx_frame_valid, .rx_frame_addr, .rx_frame_bits, .rx_error,
    .tx_frame_bits, .tx_frame_addr, .bit_period_cycles, .resync_request, .contact_output,
    .input_indicator, .output_indicator, .link_ok_indicator, .loop_indicator, .alarm_indicator,
    .tx_activity_indicator, .rx_activity_indicator, .alarm_relay_energize);
  rioc_peer_model rioc_peer_model_i (.pclk, .bit_period_cycles, .rx_frame_valid, .rx_frame_addr,
    .rx_frame_bits, .rx_error);
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [1:0] a, input logic [7:0] b);
    rioc_peer_model_i.send(a, b);
    cyc(4);
  endtask
  task automatic t_reset();
    chk("alarm", alarm_indicator, 1'b1);
    chk("relay", alarm_relay_energize, 1'b0);
    apb(1'b0, `RIOC_OFF_CTRL, 32'h0);
    chk("ctrl", rd, `RIOC_CTRL_RESET);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", err, 1'b1);
    chk("unmapped", rd, 32'h0000_0000);
    apb(1'b1, `RIOC_OFF_SWITCH, 32'hffff_ffff);
    apb(1'b0, `RIOC_OFF_SWITCH, 32'h0);
    chk("switch", rd, 32'h0000_0004);
    chk("txaddr", tx_frame_addr, 2'b00);
  endtask
  task automatic t_link();
    frame(2'b01, 8'ha5);
    chk("out", contact_output, 8'ha5);
    chk("outled", output_indicator, 8'ha5);
    chk("leds", {link_ok_indicator, tx_activity_indicator, rx_activity_indicator,
      alarm_indicator, alarm_relay_energize}, 5'h1d);
    apb(1'b0, `RIOC_OFF_OUTS, 32'h0);
    chk("outsreg", rd, 32'h0000_00a5);
    contact_input <= 8'h81;
    cyc(3);
    chk("txbits", tx_frame_bits, 8'h81);
    chk("inled", input_indicator, 8'h81);
  endtask
  task automatic t_loop();
    frame(2'b00, 8'hff);
    chk("loop", {loop_indicator, link_ok_indicator}, 2'b10);
    chk("loopout", contact_output, 8'h00);
    apb(1'b0, `RIOC_OFF_STATUS, 32'h0);
    chk("status", rd, 32'h0000_0006);
    frame(2'b01, 8'h5a);
    chk("unloop", {loop_indicator, contact_output}, 9'h05a);
  endtask
  task automatic t_secure();
    config_switch <= 10'h014;
    cyc(6);
    frame(2'b01, 8'h13);
    chk("sec1", contact_output, 8'h10);
    frame(2'b01, 8'h13);
    chk("sec2", contact_output, 8'h13);
    frame(2'b01, 8'h00);
    chk("sec3", contact_output, 8'h03);
    frame(2'b01, 8'h00);
    chk("sec4", contact_output, 8'h00);
    config_switch <= 10'h004;
    cyc(6);
  endtask
  task automatic t_lamp_ctrl();
    frame(2'b01, 8'h3c);
    indicator_test_button <= 1'b1;
    cyc(3);
    chk("lamp", {link_ok_indicator, loop_indicator, alarm_indicator, tx_activity_indicator,
      rx_activity_indicator, input_indicator, output_indicator}, 21'h1fffff);
    indicator_test_button <= 1'b0;
    cyc(3);
    chk("unlamp", {link_ok_indicator, loop_indicator, alarm_indicator}, 3'b100);
    apb(1'b1, `RIOC_OFF_CTRL, 32'h0);
    cyc(3);
    chk("ctrloff", {link_ok_indicator, contact_output}, 9'h000);
    apb(1'b1, `RIOC_OFF_CTRL, 32'h3);
    @(posedge pclk);
    chk("swresync", resync_request, 1'b1);
    apb(1'b0, `RIOC_OFF_CTRL, 32'h0);
    chk("ctrlrd", rd, 32'h0000_0001);
  endtask
  task automatic t_error();
    logic seen;
    seen = 1'b0;
    frame(2'b01, 8'h66);
    rioc_peer_model_i.fault();
    cyc(3);
    chk("errok", {link_ok_indicator, alarm_relay_energize}, 2'b01);
    rioc_peer_model_i.fault();
    repeat (4) begin
      @(posedge pclk);
      if (resync_request === 1'b1) seen = 1'b1;
    end
    chk("resync", seen, 1'b1);
    cyc(DLY + 10);
    chk("down", {alarm_relay_energize, alarm_indicator, contact_output}, 10'h100);
  endtask
  task automatic t_rate();
    for (int i = 0; i < 4; i++) begin
      frame(2'b01, 8'h3c);
      config_switch <= {i[1:0], 4'h0, ~i[1:0], i[1:0]};
      cyc(6);
      chk("period", bit_period_cycles, period_tbl[i]);
      chk("txcode", tx_frame_addr, i[1:0]);
    end
    chk("resv", {link_ok_indicator, alarm_relay_energize, contact_output}, 10'h000);
    // let the reserved-rate assertion finish its window before the run ends
    cyc(2);
  endtask
  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    cyc(4);
    t_reset();
    t_link();
    t_loop();
    t_secure();
    t_lamp_ctrl();
    t_error();
    t_rate();
    final_report();
  end
endmodule // rioc_top_tb
`default_nettype wire
